//--- verilog/cbcd_exec.sv
// execution slice for bit test, call, watchdog clear, compare, decimal adjust, interrupt disable,
// divide and bit scan; the core issues one operation at a time while o_ready is high
`timescale 1ns/1ps
module cbcd_exec #(
  parameter int DATA_W = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_issue,
  input  wire cbcd_pkg::cbcd_op_e i_op,
  input  wire logic [15:0]       i_opa,
  input  wire logic [15:0]       i_opa_hi,
  input  wire logic [15:0]       i_opb,
  input  wire logic [15:0]       i_default_working_register,
  input  wire logic [1:0]        i_opb_src,
  input  wire logic [4:0]        i_lit5,
  input  wire logic [3:0]        i_bit_lit,
  input  wire logic              i_bit_dynamic,
  input  wire logic              i_to_zero,
  input  wire logic [22:0]       i_lit23,
  input  wire logic [13:0]       i_lit14,
  input  wire logic              i_div_signed,
  input  wire logic              i_div_long,
  input  wire logic              i_next_two_word,
  input  wire logic              i_carry,
  input  wire logic              i_zero,
  input  wire logic              i_digit_carry_flag,
  output logic                   o_ready,
  output logic                   o_done,
  output logic [15:0]            o_result,
  output logic [15:0]            o_remainder,
  output logic                   o_result_we,
  output logic [4:0]             o_flags,
  output logic [4:0]             o_flags_we,
  output logic                   o_skip,
  output logic                   o_wdt_restart,
  output logic                   o_call_push,
  output logic [22:0]            o_call_target,
  output logic                   o_int_block
);
  import cbcd_pkg::*;

  // refused at elaboration: the datapath below is hard-wired to 16 bits
  if (DATA_W != 16) begin : g_data_w_check
    $error("cbcd_exec serves a 16-bit data path only");
  end

  cbcd_state_s s_reg;
  cbcd_state_s s_next;

  // ==========================================================================
  // scan helpers
  function automatic logic [15:0] first_one_left(input logic [15:0] v);
    first_one_left = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        first_one_left = 16'(16 - i);
      end
    end
  endfunction

  function automatic logic [15:0] first_one_right(input logic [15:0] v);
    first_one_right = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first_one_right = 16'(i + 1);
      end
    end
  endfunction

  function automatic logic [15:0] bit_change_left(input logic [15:0] v);
    bit_change_left = 16'h0000;
    for (int i = 0; i < 15; i++) begin
      if (v[i] != v[15]) begin
        bit_change_left = 16'(i);
      end
    end
  endfunction

  // ==========================================================================
  // operand shaping
  logic        issue;
  logic [3:0]  bit_pos;
  logic        sel_bit;
  logic [15:0] opb_sel;
  logic        cin;
  logic [16:0] sum;
  logic [8:0]  lsum;
  logic [8:0]  decimal_adjust_op;
  logic [31:0] dividend;
  logic [31:0] dvd_mag;
  logic [15:0] dvs_mag;
  logic [16:0] trial;
  logic [15:0] q_fin;

  assign o_ready = (s_reg.state == ST_IDLE);
  assign issue   = i_issue && o_ready;
  assign bit_pos = i_bit_dynamic ? i_opb[3:0] : i_bit_lit;
  assign sel_bit = i_opa[bit_pos];

  always_comb begin
    case (i_opb_src)
      SRC_DEFAULT_DEFAULT_WORKING_REGISTER: opb_sel = i_default_working_register;
      SRC_LIT5:         opb_sel = {11'h000, i_lit5};
      default:          opb_sel = i_opb;
    endcase
    if (i_op == OP_COMPARE_WITH_ZERO) begin
      opb_sel = 16'h0000;
    end
  end

  // subtraction as a + ~b + carry-in; borrow form feeds the live carry
  assign cin  = (i_op == OP_COMPARE_WITH_BORROW) ? i_carry : 1'b1;
  assign sum  = {1'b0, i_opa} + {1'b0, ~opb_sel} + {16'h0000, cin};
  assign lsum = {1'b0, i_opa[7:0]} + {1'b0, ~opb_sel[7:0]} + {8'h00, cin};

  always_comb begin
    decimal_adjust_op = {1'b0, i_opa[7:0]};
    if (decimal_adjust_op[3:0] > 4'h9 || i_digit_carry_flag) begin
      decimal_adjust_op = decimal_adjust_op + 9'h006;
    end
    if (decimal_adjust_op[7:4] > 4'h9 || i_carry || decimal_adjust_op[8]) begin
      decimal_adjust_op = decimal_adjust_op + 9'h060;
    end
  end

  // magnitudes up front so the loop is plain restoring division
  assign dividend = i_div_long ? {i_opa_hi, i_opa}
                  : (i_div_signed ? {{16{i_opa[15]}}, i_opa} : {16'h0000, i_opa});
  assign dvd_mag  = (i_div_signed && dividend[31]) ? (32'h00000000 - dividend) : dividend;
  assign dvs_mag  = (i_div_signed && i_opb[15]) ? (16'h0000 - i_opb) : i_opb;
  assign trial    = {s_reg.div_rem, s_reg.div_q[15]};
  assign q_fin    = s_reg.div_neg ? (16'h0000 - s_reg.div_q) : s_reg.div_q;

  // ==========================================================================
  // next state
  always_comb begin
    s_next           = s_reg;
    s_next.done      = 1'b0;
    s_next.skip      = 1'b0;
    s_next.wdt       = 1'b0;
    s_next.call_push = 1'b0;
    s_next.result_we = 1'b0;
    s_next.flags_we  = 5'h00;
    if (s_reg.interrupt_disable_cycles_op_cnt != '0) begin
      s_next.interrupt_disable_cycles_op_cnt = s_reg.interrupt_disable_cycles_op_cnt - INTERRUPT_DISABLE_CYCLES_OP_W'(1);
    end
    case (s_reg.state)
      ST_IDLE: begin
        if (issue) begin
          s_next.done  = 1'b1;
          s_next.flags = s_reg.flags;
          case (i_op)
            OP_TEST_BIT_SKIP_IF_SET,
            OP_COMPARE_SKIP_EQUAL,
            OP_COMPARE_SKIP_GREATER,
            OP_COMPARE_SKIP_LESS,
            OP_COMPARE_SKIP_NOT_EQUAL: begin
              if ((i_op == OP_TEST_BIT_SKIP_IF_SET && sel_bit) ||
                  (i_op == OP_COMPARE_SKIP_EQUAL && i_opa == i_opb) ||
                  (i_op == OP_COMPARE_SKIP_NOT_EQUAL && i_opa != i_opb) ||
                  (i_op == OP_COMPARE_SKIP_GREATER && $signed(i_opa) > $signed(i_opb)) ||
                  (i_op == OP_COMPARE_SKIP_LESS && $signed(i_opa) < $signed(i_opb))) begin
                s_next.skip  = 1'b1;
                s_next.state = ST_STALL;
                s_next.cnt   = i_next_two_word ? 5'(SKIP_TWO_WORD - 1)
                                               : 5'(SKIP_ONE_WORD - 1);
              end
            end
            OP_TEST_BIT_TO_FLAG,
            OP_TEST_THEN_SET_BIT: begin
              if (i_to_zero) begin
                s_next.flags[FLAG_Z]    = ~sel_bit;
                s_next.flags_we[FLAG_Z] = 1'b1;
              end else begin
                s_next.flags[FLAG_C]    = sel_bit;
                s_next.flags_we[FLAG_C] = 1'b1;
              end
              if (i_op == OP_TEST_THEN_SET_BIT) begin
                s_next.result    = i_opa | (16'h0001 << bit_pos);
                s_next.result_we = 1'b1;
              end
            end
            OP_CALL_DIRECT,
            OP_CALL_INDIRECT: begin
              s_next.call_push   = 1'b1;
              s_next.call_target = (i_op == OP_CALL_DIRECT) ? i_lit23 : {7'h00, i_opa};
              s_next.state       = ST_STALL;
              s_next.cnt         = 5'(CALL_CYCLES - 1);
            end
            OP_WATCHDOG_CLEAR: begin
              s_next.wdt = 1'b1;
            end
            OP_COMPARE,
            OP_COMPARE_WITH_BORROW,
            OP_COMPARE_WITH_ZERO: begin
              s_next.flags[FLAG_C]   = sum[16];
              s_next.flags[FLAG_DCY] = lsum[8];
              s_next.flags[FLAG_N]   = sum[15];
              s_next.flags[FLAG_OVF] = (i_opa[15] != opb_sel[15]) && (sum[15] != i_opa[15]);
              // borrow form keeps zero sticky across a multi-word compare
              s_next.flags[FLAG_Z]   = (sum[15:0] == 16'h0000) &&
                                       (i_op != OP_COMPARE_WITH_BORROW || i_zero);
              s_next.flags_we        = FLAGS_ALL;
            end
            OP_DECIMAL_ADJUST: begin
              s_next.result           = {i_opa[15:8], decimal_adjust_op[7:0]};
              s_next.result_we        = 1'b1;
              s_next.flags[FLAG_C]    = decimal_adjust_op[8] | i_carry;
              s_next.flags_we[FLAG_C] = 1'b1;
            end
            OP_INTERRUPT_DISABLE_CYCLES: begin
              s_next.interrupt_disable_cycles_op_cnt = i_lit14;
            end
            OP_DIVIDE: begin
              s_next.done     = 1'b0;
              s_next.state    = ST_DIV;
              s_next.cnt      = 5'(DIV_STEPS);
              s_next.div_rem  = dvd_mag[31:16];
              s_next.div_q    = dvd_mag[15:0];
              s_next.div_d    = dvs_mag;
              s_next.div_sgn  = i_div_signed;
              s_next.div_neg  = i_div_signed && (dividend[31] ^ i_opb[15]);
              s_next.div_rneg = i_div_signed && dividend[31];
              s_next.div_ov   = (dvs_mag == 16'h0000) || (dvd_mag[31:16] >= dvs_mag);
            end
            OP_FIND_BIT_CHANGE_LEFT: begin
              s_next.result    = bit_change_left(i_opa);
              s_next.result_we = 1'b1;
            end
            OP_FIND_FIRST_ONE_LEFT,
            OP_FIND_FIRST_ONE_RIGHT: begin
              s_next.result           = (i_op == OP_FIND_FIRST_ONE_LEFT) ? first_one_left(i_opa)
                                                                         : first_one_right(i_opa);
              s_next.result_we        = 1'b1;
              s_next.flags[FLAG_C]    = (i_opa == 16'h0000);
              s_next.flags_we[FLAG_C] = 1'b1;
            end
            default: begin
              s_next.done = 1'b0;
            end
          endcase
        end
      end
      ST_STALL: begin
        s_next.cnt = s_reg.cnt - 5'h01;
        if (s_reg.cnt == 5'h01) begin
          s_next.state = ST_IDLE;
        end
      end
      ST_DIV: begin
        if (s_reg.cnt != 5'h00) begin
          s_next.cnt   = s_reg.cnt - 5'h01;
          s_next.div_q = {s_reg.div_q[14:0], trial >= {1'b0, s_reg.div_d}};
          s_next.div_rem = (trial >= {1'b0, s_reg.div_d}) ? 16'(trial - {1'b0, s_reg.div_d})
                                                         : trial[15:0];
        end else begin
          // a signed quotient past the 16-bit range counts as overflow
          s_next.result            = q_fin;
          s_next.remainder         = s_reg.div_rneg ? (16'h0000 - s_reg.div_rem) : s_reg.div_rem;
          s_next.result_we         = 1'b1;
          s_next.flags[FLAG_N]     = q_fin[15];
          s_next.flags[FLAG_Z]     = (q_fin == 16'h0000);
          s_next.flags[FLAG_C]     = (s_reg.div_rem != 16'h0000);
          s_next.flags[FLAG_OVF]   = s_reg.div_ov || (s_reg.div_sgn && s_reg.div_q[15] &&
                                     !(s_reg.div_neg && s_reg.div_q == 16'h8000));
          s_next.flags_we          = FLAGS_DIV;
          s_next.done              = 1'b1;
          s_next.state             = ST_IDLE;
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_reg       <= '0;
      s_reg.state <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_done        = s_reg.done;
  assign o_result      = s_reg.result;
  assign o_remainder   = s_reg.remainder;
  assign o_result_we   = s_reg.result_we;
  assign o_flags       = s_reg.flags;
  assign o_flags_we    = s_reg.flags_we;
  assign o_skip        = s_reg.skip;
  assign o_wdt_restart = s_reg.wdt;
  assign o_call_push   = s_reg.call_push;
  assign o_call_target = s_reg.call_target;
  assign o_int_block   = (s_reg.interrupt_disable_cycles_op_cnt != '0);

  // ==========================================================================
  // checks
  skip_stall_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_TEST_BIT_SKIP_IF_SET && sel_bit && !i_next_two_word
    |=> o_skip && !o_ready && o_flags_we == 5'h00 ##1 o_ready)
    else $error("skip over one word did not take two cycles");
  skip_long_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_COMPARE_SKIP_EQUAL && i_opa == i_opb && i_next_two_word
    |=> o_skip ##0 !o_ready [*2] ##1 o_ready)
    else $error("skip over two words did not take three cycles");
  test_flag_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_TEST_BIT_TO_FLAG && !i_to_zero
    |=> o_flags_we == 5'h01 && o_flags[FLAG_C] == $past(sel_bit) && !o_result_we)
    else $error("tested bit not copied to carry");
  test_set_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_TEST_THEN_SET_BIT
    |=> o_result_we && o_result == ($past(i_opa) | (16'h0001 << $past(bit_pos))))
    else $error("tested bit not set afterwards");
  call_len_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && (i_op == OP_CALL_DIRECT || i_op == OP_CALL_INDIRECT)
    |=> o_call_push && !o_ready && o_flags_we == 5'h00 ##1 o_ready)
    else $error("call did not take two cycles");
  wdt_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_WATCHDOG_CLEAR |=> o_wdt_restart && o_ready ##1 !o_wdt_restart)
    else $error("watchdog restart not a single pulse");
  compare_nostore_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_COMPARE |=> !o_result_we && o_flags_we == 5'h1F
    && o_flags[FLAG_Z] == ($past(i_opa) == $past(opb_sel)))
    else $error("compare stored a result or missed flags");
  interrupt_disable_cycles_op_block_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_INTERRUPT_DISABLE_CYCLES && i_lit14 > 14'h0002
    |=> o_int_block [*3])
    else $error("interrupts not blocked after disable");
  div_len_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_DIVIDE |=> !o_ready ##16 !o_ready && !o_done ##1 o_done && o_ready
    && o_flags_we == 5'h0F)
    else $error("divide did not finish in 18 cycles");
  ff1_none_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    issue && i_op == OP_FIND_FIRST_ONE_LEFT |=> o_flags[FLAG_C] == ($past(i_opa) == 16'h0000)
    && o_result_we)
    else $error("find first one carry wrong");

endmodule

//--- verilog/cbcd_pkg.sv
// constants, opcodes and state types for the bit, compare and divide execution slice
// assumes a core that decodes instructions, reads operands and retires results itself
// Operation
// - test-bit-skip-if-set takes one word and one cycle, or two or three when it skips the next one- or two-word instruction on a set bit, no flags.
// - test-bit copies the selected bit, chosen by literal or by a register, into carry, or its complement into zero, in one cycle.
// - test-then-set captures the selected bit into carry, or its complement into zero, then sets that bit, in one cycle.
// - subroutine call takes two cycles, direct with a 23-bit target or indirect from a register, no flags.
// - watchdog clear restarts the watchdog with a one-cycle pulse, no flags.
// - compare subtracts the second operand from the first without storing, updating all five flags.
// - compare-with-borrow also subtracts the inverted carry, updating all five flags in one cycle.
// - compare-with-zero compares an operand against zero, updating all five flags in one cycle.
// - compare-and-skip tests equal, greater, less or not equal and skips when true, no flags.
// - decimal adjust corrects the low byte to packed BCD, updates only carry, in one cycle.
// - interrupt disable blocks interrupts for a 14-bit literal count of cycles, no flags.
// - divide is signed or unsigned 16/16 or 32/16 in 18 cycles, updating negative, zero, carry, overflow.
// - find-bit-change scans from the msb for the first bit unlike the sign, one cycle, no flags.
// - find-first-one-left finds the highest set bit in one cycle and updates carry.
// - find-first-one-right finds the lowest set bit in one cycle and updates carry.
package cbcd_pkg;

  // ==========================================================================
  // opcodes
  typedef enum logic [4:0] {
    OP_TEST_BIT_SKIP_IF_SET     = 5'h00,
    OP_TEST_BIT_TO_FLAG         = 5'h01,
    OP_TEST_THEN_SET_BIT        = 5'h02,
    OP_CALL_DIRECT              = 5'h03,
    OP_CALL_INDIRECT            = 5'h04,
    OP_WATCHDOG_CLEAR           = 5'h05,
    OP_COMPARE                  = 5'h06,
    OP_COMPARE_WITH_BORROW      = 5'h07,
    OP_COMPARE_WITH_ZERO        = 5'h08,
    OP_COMPARE_SKIP_EQUAL       = 5'h09,
    OP_COMPARE_SKIP_GREATER     = 5'h0A,
    OP_COMPARE_SKIP_LESS        = 5'h0B,
    OP_COMPARE_SKIP_NOT_EQUAL   = 5'h0C,
    OP_DECIMAL_ADJUST           = 5'h0D,
    OP_INTERRUPT_DISABLE_CYCLES = 5'h0E,
    OP_DIVIDE                   = 5'h0F,
    OP_FIND_BIT_CHANGE_LEFT     = 5'h10,
    OP_FIND_FIRST_ONE_LEFT      = 5'h11,
    OP_FIND_FIRST_ONE_RIGHT     = 5'h12
  } cbcd_op_e;

  // second operand source for compare and compare-with-borrow; compare-and-skip always takes i_opb
  localparam logic [1:0] SRC_DEFAULT_DEFAULT_WORKING_REGISTER = 2'h0;
  localparam logic [1:0] SRC_LIT5         = 2'h1;
  localparam logic [1:0] SRC_REGISTER     = 2'h2;

  // ==========================================================================
  // flag vector positions
  localparam int FLAG_C   = 0;
  localparam int FLAG_Z   = 1;
  localparam int FLAG_OVF = 2;
  localparam int FLAG_N   = 3;
  localparam int FLAG_DCY = 4;
  localparam logic [4:0] FLAGS_ALL = 5'h1F;
  localparam logic [4:0] FLAGS_DIV = 5'h0F;

  // ==========================================================================
  // timing counts, in instruction cycles
  localparam int CALL_CYCLES   = 2;
  localparam int SKIP_ONE_WORD = 2;
  localparam int SKIP_TWO_WORD = 3;
  localparam int DIV_CYCLES    = 18;
  localparam int DIV_STEPS     = DIV_CYCLES - 2;
  localparam int INTERRUPT_DISABLE_CYCLES_OP_W        = 14;

  // ==========================================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_STALL = 3'b010,
    ST_DIV   = 3'b100
  } cbcd_state_e;

  typedef struct packed {
    cbcd_state_e       state;
    logic [4:0]        cnt;
    logic [15:0]       div_rem;
    logic [15:0]       div_q;
    logic [15:0]       div_d;
    logic              div_neg;
    logic              div_rneg;
    logic              div_sgn;
    logic              div_ov;
    logic [INTERRUPT_DISABLE_CYCLES_OP_W-1:0] interrupt_disable_cycles_op_cnt;
    logic [15:0]       result;
    logic [15:0]       remainder;
    logic              result_we;
    logic [4:0]        flags;
    logic [4:0]        flags_we;
    logic              done;
    logic              skip;
    logic              wdt;
    logic              call_push;
    logic [22:0]       call_target;
  } cbcd_state_s;

endpackage

//--- sim/cbcd_core_model.sv
// core-side partner: the status register that the execution slice updates
// assumes flags arrive as {dc,n,ov,z,c} with a write enable per flag
`timescale 1ns/1ps
module cbcd_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic [4:0] i_flags,
  input  wire logic [4:0] i_flags_we,
  output logic            o_carry,
  output logic            o_zero,
  output logic            o_dc
);
  import cbcd_pkg::*;
  // ==========================================================================
  // status register; a flag without its enable keeps its value
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_carry <= 1'b0;
      o_zero  <= 1'b0;
      o_dc    <= 1'b0;
    end else begin
      if (i_flags_we[FLAG_C]) begin
        o_carry <= i_flags[FLAG_C];
      end
      if (i_flags_we[FLAG_Z]) begin
        o_zero <= i_flags[FLAG_Z];
      end
      if (i_flags_we[FLAG_DCY]) begin
        o_dc <= i_flags[FLAG_DCY];
      end
    end
  end
endmodule

//--- sim/cpu_bit_compare_divide_ops_tb.sv
// self-checking bench for the execution slice, with the core status register as partner
// assumes inputs change on the falling edge and outputs are read there
`timescale 1ns/1ps
module cpu_bit_compare_divide_ops_tb;
  import cbcd_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_issue = 1'b0;
  cbcd_op_e i_op = OP_COMPARE;
  logic [15:0] i_opa = 16'h0, i_opa_hi = 16'h0, i_opb = 16'h0, i_dwr = 16'h0;
  logic [1:0] i_opb_src = SRC_REGISTER;
  logic [4:0] i_lit5 = 5'h0;
  logic [3:0] i_bit_lit = 4'h0;
  logic i_bit_dynamic = 1'b0, i_to_zero = 1'b0, i_div_signed = 1'b0, i_div_long = 1'b0;
  logic [22:0] i_lit23 = 23'h0;
  logic [13:0] i_lit14 = 14'h0;
  logic i_next_two_word = 1'b0, carry, zero, dc;
  logic o_ready, o_done, o_result_we, o_skip, o_wdt_restart, o_call_push, o_int_block;
  logic [15:0] o_result, o_remainder;
  logic [4:0] o_flags, o_flags_we;
  logic [22:0] o_call_target;
  int err_count = 0, total_checks = 0, n = 0;

  cbcd_exec dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_issue(i_issue), .i_op(i_op),
    .i_opa(i_opa), .i_opa_hi(i_opa_hi), .i_opb(i_opb), .i_default_working_register(i_dwr),
    .i_opb_src(i_opb_src), .i_lit5(i_lit5), .i_bit_lit(i_bit_lit), .i_bit_dynamic(i_bit_dynamic),
    .i_to_zero(i_to_zero), .i_lit23(i_lit23), .i_lit14(i_lit14), .i_div_signed(i_div_signed),
    .i_div_long(i_div_long), .i_next_two_word(i_next_two_word), .i_carry(carry), .i_zero(zero),
    .i_digit_carry_flag(dc), .o_ready(o_ready), .o_done(o_done), .o_result(o_result),
    .o_remainder(o_remainder), .o_result_we(o_result_we), .o_flags(o_flags),
    .o_flags_we(o_flags_we), .o_skip(o_skip), .o_wdt_restart(o_wdt_restart),
    .o_call_push(o_call_push), .o_call_target(o_call_target), .o_int_block(o_int_block));
  cbcd_core_model core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_flags(o_flags),
    .i_flags_we(o_flags_we), .o_carry(carry), .o_zero(zero), .o_dc(dc));

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // ==========================================================================
  // shared tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // issue at a falling edge while idle, then count cycles up to the done pulse
  task automatic go(input cbcd_op_e op);
    i_op = op;
    i_issue = 1'b1;
    n = 0;
    do begin
      @(negedge i_clk);
      i_issue = 1'b0;
      n++;
    end while (o_done !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // cycles the slice stays busy after the done pulse
  task automatic stall();
    n = 0;
    while (o_ready !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_compare();
    i_opa = 16'h0005;
    i_opb = 16'h0007;
    go(OP_COMPARE);
    chk("cmp cycles", 1, n);
    chk("cmp flags", 5'h08, o_flags);
    chk("cmp flags_we", 5'h1F, o_flags_we);
    i_opa = 16'h0003;
    i_opb = 16'h0003;
    go(OP_COMPARE_WITH_BORROW);
    chk("cpb flags", 5'h08, o_flags);
    i_opa = 16'h0010;
    i_lit5 = 5'h10;
    i_opb_src = SRC_LIT5;
    go(OP_COMPARE);
    chk("cmp lit flags", 5'h13, o_flags);
    i_opa = 16'h0000;
    go(OP_COMPARE_WITH_ZERO);
    chk("cp0 flags", 5'h13, o_flags);
    i_opa = 16'h0005;
    i_dwr = 16'h0007;
    i_opb_src = SRC_DEFAULT_DEFAULT_WORKING_REGISTER;
    go(OP_COMPARE);
    chk("cp default_working_register flags", 5'h08, o_flags);
    // one idle cycle so the status register holds the cleared carry and digit carry
    @(negedge i_clk);
    i_opa = 16'h123C;
    go(OP_DECIMAL_ADJUST);
    chk("daw result", 16'h1242, o_result);
    chk("daw result_we", 1, o_result_we);
    chk("daw flags_we", 5'h01, o_flags_we);
    chk("daw c", 0, o_flags[FLAG_C]);
    $display("test compare done");
  endtask
  task automatic t_skip();
    i_opa = 16'h8000;
    i_bit_lit = 4'hF;
    go(OP_TEST_BIT_SKIP_IF_SET);
    chk("test_bit_skip_if_set skip", 1, o_skip);
    chk("test_bit_skip_if_set flags_we", 0, o_flags_we);
    stall();
    chk("test_bit_skip_if_set stall", SKIP_ONE_WORD - 1, n);
    i_opb = 16'h8000;
    i_next_two_word = 1'b1;
    go(OP_COMPARE_SKIP_EQUAL);
    chk("compare_skip_equal skip", 1, o_skip);
    stall();
    chk("compare_skip_equal stall", SKIP_TWO_WORD - 1, n);
    i_opa = 16'hFFFF;
    i_opb = 16'h0001;
    go(OP_COMPARE_SKIP_GREATER);
    chk("compare_skip_greater skip", 0, o_skip);
    stall();
    chk("compare_skip_greater stall", 0, n);
    i_next_two_word = 1'b0;
    go(OP_COMPARE_SKIP_LESS);
    chk("compare_skip_less skip", 1, o_skip);
    stall();
    chk("compare_skip_less stall", SKIP_ONE_WORD - 1, n);
    i_opb = 16'hFFFF;
    go(OP_COMPARE_SKIP_NOT_EQUAL);
    chk("compare_skip_not_equal skip", 0, o_skip);
    $display("test skip done");
  endtask
  task automatic t_bits();
    i_opa = 16'h0000;
    i_opb = 16'h0003;
    i_bit_dynamic = 1'b1;
    i_to_zero = 1'b1;
    go(OP_TEST_THEN_SET_BIT);
    chk("test_then_set_bit result", 16'h0008, o_result);
    chk("test_then_set_bit flags_we", 5'h02, o_flags_we);
    chk("test_then_set_bit z", 1, o_flags[FLAG_Z]);
    i_opa = 16'h0100;
    go(OP_FIND_FIRST_ONE_LEFT);
    chk("find_first_one_left result", 16'h0008, o_result);
    chk("find_first_one_left flags_we", 5'h01, o_flags_we);
    chk("find_first_one_left c", 0, o_flags[FLAG_C]);
    go(OP_FIND_FIRST_ONE_RIGHT);
    chk("find_first_one_right result", 16'h0009, o_result);
    i_opa = 16'hF0FF;
    go(OP_FIND_BIT_CHANGE_LEFT);
    chk("find_bit_change_left result", 16'h000B, o_result);
    chk("find_bit_change_left flags_we", 0, o_flags_we);
    i_opa = 16'h0004;
    i_bit_lit = 4'h2;
    i_bit_dynamic = 1'b0;
    i_to_zero = 1'b0;
    go(OP_TEST_BIT_TO_FLAG);
    chk("test_bit_to_flag c", 1, o_flags[FLAG_C]);
    chk("test_bit_to_flag result_we", 0, o_result_we);
    $display("test bits done");
  endtask
  task automatic t_call();
    i_lit23 = 23'h12345;
    go(OP_CALL_DIRECT);
    chk("call push", 1, o_call_push);
    chk("call target", 23'h12345, o_call_target);
    chk("call flags_we", 0, o_flags_we);
    stall();
    chk("call stall", CALL_CYCLES - 1, n);
    i_opa = 16'h1234;
    go(OP_CALL_INDIRECT);
    chk("calli target", 23'h001234, o_call_target);
    stall();
    chk("calli stall", CALL_CYCLES - 1, n);
    go(OP_WATCHDOG_CLEAR);
    chk("wdt restart", 1, o_wdt_restart);
    $display("test call done");
  endtask
  task automatic t_div();
    i_opa = 16'd100;
    i_opb = 16'd7;
    go(OP_DIVIDE);
    chk("div cycles", DIV_CYCLES, n);
    chk("div quotient", 16'h000E, o_result);
    chk("div remainder", 16'h0002, o_remainder);
    chk("div flags_we", FLAGS_DIV, o_flags_we);
    chk("div flags", 4'h1, o_flags[3:0]);
    i_opa = 16'hFF9C;
    i_div_signed = 1'b1;
    go(OP_DIVIDE);
    chk("sdiv quotient", 16'hFFF2, o_result);
    chk("sdiv remainder", 16'hFFFE, o_remainder);
    chk("sdiv flags", 4'h9, o_flags[3:0]);
    i_div_signed = 1'b0;
    i_opb = 16'h0000;
    go(OP_DIVIDE);
    chk("div0 ov", 1, o_flags[FLAG_OVF]);
    $display("test divide done");
  endtask
  task automatic t_interrupt_disable_cycles_op();
    i_lit14 = 14'h0005;
    go(OP_INTERRUPT_DISABLE_CYCLES);
    n = 0;
    while (o_int_block === 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      tally_and_finish();
    end
    chk("interrupt_disable_cycles_op span", 5, n);
    $display("test disable done");
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(negedge i_clk);
    i_reset_n = 1'b1;
    t_compare();
    t_skip();
    t_bits();
    t_call();
    t_div();
    t_interrupt_disable_cycles_op();
    tally_and_finish();
  end
endmodule
